// ===== logic/typb_reader_framing.sv
// Type B reader framing: WUPB/ATTRIB sequencing, etu character timing and answer closing.
module typb_reader_framing
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              link_clk,
    input  wire logic              poll_start,
    input  wire logic              cmd_valid,
    input  wire typb_pkg::typb_byte_s cmd,
    output logic                   cmd_ready,
    output logic                   tx_mod,
    input  wire logic              rx_sc_on,
    input  wire logic              rx_char_valid,
    input  wire logic [7:0]        rx_char,
    input  wire logic              rx_eos,
    output logic                   busy,
    output logic                   atqb_ok,
    output logic                   atqb_fail,
    output logic                   attrib_done
);
    import typb_pkg::*;

    localparam int ETU_A   = ETU_FC;
    localparam int RUNON_A = SUBCARRIER_RUNON_AFTER_EOS_MAX_FC + 1;

    typb_sys_s  s_q, s_d;
    typb_link_s l_q, l_d;
    logic       link_rst_s1, link_rst_q;
    logic       rslt_good;

    // Returns the modulation level for a bit slot: modulated means logic zero.
    function automatic logic typb_mod_for(input logic [3:0] bit_idx, input logic [7:0] data);
        logic m;
        m = 1'b0;
        if (bit_idx == START_BIT)
            m = 1'b1;
        else if (bit_idx != STOP_BIT)
            m = ~data[3'(bit_idx - BIT_ONE)];
        return m;
    endfunction

    // Returns byte idx of the fixed wake-up frame, first byte first.
    function automatic logic [7:0] typb_wupb_byte(input logic [2:0] idx);
        logic [39:0] sh;
        sh = WUPB_FRAME << {idx, 3'h0};
        return sh[39:32];
    endfunction

    // Link reset follows the system reset through two flops.
    always_ff @(posedge link_clk)
    begin
        link_rst_s1 <= rst;
        link_rst_q  <= link_rst_s1;
    end

    // Link domain: transmitter and receiver on the carrier-rate clock.
    always_comb
    begin
        l_d        = l_q;
        l_d.req_s1 = s_q.req_tgl;
        l_d.req_s2 = l_q.req_s1;
        if (l_q.cnt != CNT_ZERO)
            l_d.cnt = l_q.cnt - CNT_ONE;
        unique case (l_q.st)
            L_IDLE:
                if (l_q.req_s2 != l_q.req_seen)
                begin
                    l_d.st     = L_SOS_LOW;
                    l_d.cnt    = SOS_LOW_CYC - CNT_ONE;
                    l_d.tx_mod = 1'b1;
                end
            L_SOS_LOW:
                if (l_q.cnt == CNT_ZERO)
                begin
                    l_d.st     = L_SOS_HIGH;
                    l_d.cnt    = SOS_HIGH_CYC - CNT_ONE;
                    l_d.tx_mod = 1'b0;
                end
            L_SOS_HIGH, L_CHAR:
                if (l_q.cnt == CNT_ZERO)
                begin
                    if (l_q.st == L_SOS_HIGH || (l_q.bit_idx == STOP_BIT && !l_q.cur.last
                        && l_q.req_s2 != l_q.req_seen))
                    begin
                        l_d.st       = L_CHAR;
                        l_d.cur      = s_q.tx;
                        l_d.req_seen = l_q.req_s2;
                        l_d.ack_tgl  = ~l_q.ack_tgl;
                        l_d.bit_idx  = START_BIT;
                        l_d.cnt      = ETU_CYC - CNT_ONE;
                        l_d.tx_mod   = typb_mod_for(START_BIT, s_q.tx.data);
                    end
                    else if (l_q.bit_idx == STOP_BIT)
                    begin
                        l_d.st     = L_EOS;
                        l_d.cnt    = EOS_LOW_CYC - CNT_ONE;
                        l_d.tx_mod = 1'b1;
                    end
                    else
                    begin
                        l_d.bit_idx = l_q.bit_idx + BIT_ONE;
                        l_d.cnt     = ETU_CYC - CNT_ONE;
                        l_d.tx_mod  = typb_mod_for(l_q.bit_idx + BIT_ONE, l_q.cur.data);
                    end
                end
            L_EOS:
                if (l_q.cnt == CNT_ZERO)
                begin
                    l_d.st     = L_RX;
                    l_d.tx_mod = 1'b0;
                    l_d.rx_cnt = '0;
                    l_d.hdr_ok = 1'b0;
                end
            L_RX:
            begin
                if (rx_char_valid)
                begin
                    if (l_q.rx_cnt == '0)
                        l_d.hdr_ok = (rx_char == ATQB_HDR);
                    if (l_q.rx_cnt != RX_CNT_MAX)
                        l_d.rx_cnt = l_q.rx_cnt + RX_CNT_ONE;
                end
                if (rx_eos)
                begin
                    l_d.st  = L_RUNON;
                    l_d.cnt = RUNON_CYC;
                end
            end
            L_RUNON:
                // Trailing subcarrier is waited out, never counted as an error.
                if (!rx_sc_on || l_q.cnt == CNT_ZERO)
                begin
                    l_d.st          = L_IDLE;
                    l_d.rslt.count  = l_q.rx_cnt;
                    l_d.rslt.hdr_ok = l_q.hdr_ok;
                    l_d.rslt_tgl    = ~l_q.rslt_tgl;
                end
            default:
                l_d.st = L_IDLE;
        endcase
    end

    always_ff @(posedge link_clk)
    begin
        if (link_rst_q)
            l_q <= LINK_RST;
        else
            l_q <= l_d;
    end
    // System domain: command sequencer.
    assign rslt_good = l_q.rslt.hdr_ok && l_q.rslt.count == ATQB_LEN;

    always_comb
    begin
        s_d           = s_q;
        s_d.ack_s1    = l_q.ack_tgl;
        s_d.ack_s2    = s_q.ack_s1;
        s_d.rslt_s1   = l_q.rslt_tgl;
        s_d.rslt_s2   = s_q.rslt_s1;
        s_d.atqb_ok   = 1'b0;
        s_d.atqb_fail = 1'b0;
        s_d.done      = 1'b0;
        unique case (s_q.st)
            S_IDLE:
                if (poll_start)
                begin
                    s_d.st      = S_WUPB;
                    s_d.tx.data = typb_wupb_byte('0);
                    s_d.tx.last = 1'b0;
                    s_d.idx     = IDX_ONE;
                    s_d.req_tgl = ~s_q.req_tgl;
                    s_d.rslt_seen = s_q.rslt_s2;
                end
            S_WUPB:
                if (s_q.ack_s2 != s_q.ack_seen)
                begin
                    s_d.ack_seen = s_q.ack_s2;
                    if (s_q.tx.last)
                        s_d.st = S_WAIT;
                    else
                    begin
                        s_d.tx.data = typb_wupb_byte(s_q.idx);
                        s_d.tx.last = (s_q.idx == WUPB_LAST_IDX);
                        s_d.idx     = s_q.idx + IDX_ONE;
                        s_d.req_tgl = ~s_q.req_tgl;
                    end
                end
            S_WAIT:
                if (s_q.rslt_s2 != s_q.rslt_seen)
                begin
                    s_d.rslt_seen = s_q.rslt_s2;
                    if (rslt_good)
                    begin
                        s_d.st      = S_ATTRIB;
                        s_d.want    = 1'b1;
                        s_d.atqb_ok = 1'b1;
                    end
                    else
                    begin
                        s_d.st        = S_IDLE;
                        s_d.atqb_fail = 1'b1;
                    end
                end
            S_ATTRIB:
                if (s_q.want && cmd_valid)
                begin
                    s_d.tx      = cmd;
                    s_d.want    = 1'b0;
                    s_d.req_tgl = ~s_q.req_tgl;
                end
                else if (!s_q.want && s_q.ack_s2 != s_q.ack_seen)
                begin
                    s_d.ack_seen = s_q.ack_s2;
                    if (s_q.tx.last)
                    begin
                        s_d.st   = S_IDLE;
                        s_d.done = 1'b1;
                    end
                    else
                        s_d.want = 1'b1;
                end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s_q <= SYS_RST;
        else
            s_q <= s_d;
    end

    assign cmd_ready   = (s_q.st == S_ATTRIB) && s_q.want;
    assign busy        = (s_q.st != S_IDLE);
    assign atqb_ok     = s_q.atqb_ok;
    assign atqb_fail   = s_q.atqb_fail;
    assign attrib_done = s_q.done;
    assign tx_mod      = l_q.tx_mod;

    // Checks on the transmitter, receiver and sequencer.
    property p_grid;
        @(posedge link_clk) disable iff (link_rst_q)
        (l_q.st == L_CHAR && $past(l_q.st) == L_CHAR && $changed(l_q.tx_mod)) |-> l_q.cnt == ETU_CYC - CNT_ONE;
    endproperty
    a_grid: assert property (p_grid) else $error("Bit edge off the etu grid.");

    property p_etu;
        @(posedge link_clk) disable iff (link_rst_q)
        (l_q.st == L_CHAR && l_q.cnt == ETU_CYC - CNT_ONE && l_q.bit_idx != STOP_BIT)
            |-> ##[ETU_A:ETU_A] (l_q.bit_idx == $past(l_q.bit_idx, ETU_A) + BIT_ONE);
    endproperty
    a_etu: assert property (p_etu) else $error("Bit period is not one etu.");

    property p_start;
        @(posedge link_clk) disable iff (link_rst_q)
        (l_q.st == L_CHAR && l_q.bit_idx == START_BIT) |-> l_q.tx_mod;
    endproperty
    a_start: assert property (p_start) else $error("Start bit not modulated.");

    property p_stop;
        @(posedge link_clk) disable iff (link_rst_q)
        (l_q.st == L_CHAR && l_q.bit_idx == STOP_BIT) |-> !l_q.tx_mod;
    endproperty
    a_stop: assert property (p_stop) else $error("Stop bit is modulated.");

    sequence s_final_stop;
        l_q.st == L_CHAR && l_q.bit_idx == STOP_BIT && l_q.cnt == CNT_ZERO && l_q.cur.last;
    endsequence
    sequence s_eos_begin;
        l_q.st == L_EOS && l_q.tx_mod && l_q.cnt == EOS_LOW_CYC - CNT_ONE;
    endsequence
    property p_eos;
        @(posedge link_clk) disable iff (link_rst_q)
        s_final_stop |=> s_eos_begin;
    endproperty
    a_eos: assert property (p_eos) else $error("End of sequence not immediate.");

    property p_close;
        @(posedge link_clk) disable iff (link_rst_q)
        (l_q.st == L_RX && rx_eos) |=> l_q.st == L_RUNON;
    endproperty
    a_close: assert property (p_close) else $error("Frame not closed on card end of sequence.");

    property p_runon_max;
        @(posedge link_clk) disable iff (link_rst_q)
        $rose(l_q.st == L_RUNON) |-> ##[1:RUNON_A] (l_q.st == L_IDLE);
    endproperty
    a_runon_max: assert property (p_runon_max) else $error("Run-on wait too long.");

    property p_runon_zero;
        @(posedge link_clk) disable iff (link_rst_q)
        (l_q.st == L_RUNON && !rx_sc_on) |=> (l_q.st == L_IDLE && $changed(l_q.rslt_tgl));
    endproperty
    a_runon_zero: assert property (p_runon_zero) else $error("Zero run-on answer not closed.");

    property p_attrib;
        @(posedge clock) disable iff (rst)
        (s_q.st == S_WAIT && s_q.rslt_s2 != s_q.rslt_seen && rslt_good) |=> (s_q.st == S_ATTRIB && cmd_ready && atqb_ok);
    endproperty
    a_attrib: assert property (p_attrib) else $error("No move to ATTRIB after good answer.");

endmodule // typb_reader_framing

// ===== logic/typb_pkg.sv
// Constants and types for the Type B reader character framing block.
// Summary of operation
// - After WUPB and a well-formed ATQB, the reader goes on to send ATTRIB.
// - A card subcarrier running up to 272 carrier periods past EoS is accepted.
// - A card subcarrier stopping right at EoS is also accepted as valid.
// - Each bit boundary n (1..9) lies within 8 carrier periods of n etu.
// - Transmit bit rate is carrier divided by 128, one etu is 128 periods.
// - Characters are low start, eight data bits LSB first modulated-is-zero, high stop.
// - Reader EoS starts right after the last stop bit, with no guard time.
package typb_pkg;

    localparam int unsigned FC_PER_LINK_CYCLE                  = 1;
    localparam int unsigned ETU_FC                             = 128;
    localparam int unsigned SOS_LOW_FC                         = 1280;
    localparam int unsigned SOS_HIGH_FC                        = 256;
    localparam int unsigned EOS_LOW_FC                         = 1280;
    localparam int unsigned SUBCARRIER_RUNON_AFTER_EOS_MAX_FC  = 272;

    localparam int CNT_W = 11;
    typedef logic [CNT_W-1:0] typb_cnt_t;

    localparam typb_cnt_t ETU_CYC      = typb_cnt_t'(ETU_FC / FC_PER_LINK_CYCLE);
    localparam typb_cnt_t SOS_LOW_CYC  = typb_cnt_t'(SOS_LOW_FC / FC_PER_LINK_CYCLE);
    localparam typb_cnt_t SOS_HIGH_CYC = typb_cnt_t'(SOS_HIGH_FC / FC_PER_LINK_CYCLE);
    localparam typb_cnt_t EOS_LOW_CYC  = typb_cnt_t'(EOS_LOW_FC / FC_PER_LINK_CYCLE);
    localparam typb_cnt_t RUNON_CYC    = typb_cnt_t'(SUBCARRIER_RUNON_AFTER_EOS_MAX_FC / FC_PER_LINK_CYCLE);
    localparam typb_cnt_t CNT_ONE      = 11'h001;
    localparam typb_cnt_t CNT_ZERO     = 11'h000;

    localparam logic [3:0]  START_BIT     = 4'h0;
    localparam logic [3:0]  STOP_BIT      = 4'h9;
    localparam logic [3:0]  BIT_ONE       = 4'h1;
    localparam logic [39:0] WUPB_FRAME    = 40'h0500083973;
    localparam logic [2:0]  WUPB_LAST_IDX = 3'h4;
    localparam logic [2:0]  IDX_ONE       = 3'h1;
    localparam logic [7:0]  ATQB_HDR      = 8'h50;
    localparam logic [4:0]  ATQB_LEN      = 5'h0E;
    localparam logic [4:0]  RX_CNT_MAX    = 5'h1F;
    localparam logic [4:0]  RX_CNT_ONE    = 5'h01;

    typedef enum logic [2:0] {L_IDLE, L_SOS_LOW, L_SOS_HIGH, L_CHAR, L_EOS, L_RX, L_RUNON} typb_link_e;
    typedef enum logic [1:0] {S_IDLE, S_WUPB, S_WAIT, S_ATTRIB} typb_seq_e;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } typb_byte_s;

    typedef struct packed {
        logic [4:0] count;
        logic       hdr_ok;
    } typb_rslt_s;

    typedef struct packed {
        typb_link_e st;
        logic       req_s1;
        logic       req_s2;
        logic       req_seen;
        typb_cnt_t  cnt;
        logic [3:0] bit_idx;
        typb_byte_s cur;
        logic       tx_mod;
        logic       ack_tgl;
        logic [4:0] rx_cnt;
        logic       hdr_ok;
        typb_rslt_s rslt;
        logic       rslt_tgl;
    } typb_link_s;

    typedef struct packed {
        typb_seq_e  st;
        logic       ack_s1;
        logic       ack_s2;
        logic       ack_seen;
        logic       rslt_s1;
        logic       rslt_s2;
        logic       rslt_seen;
        logic       req_tgl;
        typb_byte_s tx;
        logic [2:0] idx;
        logic       want;
        logic       atqb_ok;
        logic       atqb_fail;
        logic       done;
    } typb_sys_s;

    localparam typb_link_s LINK_RST = '{st: L_IDLE, cnt: CNT_ZERO, bit_idx: START_BIT, default: '0};
    localparam typb_sys_s  SYS_RST  = '{st: S_IDLE, default: '0};

endpackage

// ===== sim/typb_card_model.sv
// Behavioural Type B card that answers a reader frame on the decoded receive lines.
module typb_card_model
(
    input  wire logic       link_clk,
    input  wire logic       answer,
    input  wire logic [7:0] hdr,
    input  wire logic [9:0] runon,
    output logic            rx_sc_on,
    output logic            rx_char_valid,
    output logic [7:0]      rx_char,
    output logic            rx_eos
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        rx_sc_on      = 1'b0;
        rx_char_valid = 1'b0;
        rx_char       = 8'hA5;
        rx_eos        = 1'b0;
        forever
        begin
            @(posedge link_clk);
            rx_char <= ~rx_char;
            if (answer)
            begin
                rx_sc_on <= 1'b1;
                repeat (8) @(posedge link_clk);
                for (int i = 0; i < 14; i++)
                begin
                    rx_char_valid <= 1'b1;
                    rx_char       <= (i == 0) ? hdr : 8'(i);
                    @(posedge link_clk);
                    rx_char_valid <= 1'b0;
                    repeat (3)
                    begin
                        rx_char <= ~rx_char;
                        @(posedge link_clk);
                    end
                end
                rx_eos <= 1'b1;
                if (runon == 10'h000)
                    rx_sc_on <= 1'b0;
                @(posedge link_clk);
                rx_eos <= 1'b0;
                if (runon > 10'h001)
                    repeat (runon - 10'h001) @(posedge link_clk);
                rx_sc_on <= 1'b0;
            end
        end
    end
endmodule // typb_card_model

// ===== sim/tb_typeb_reader_char_framing.sv
// Testbench for the Type B reader framing block with a card model.
module tb_typeb_reader_char_framing;
    timeunit 1ns;
    timeprecision 100ps;
    import typb_pkg::*;

    logic       clock = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst = 1'b1;
    logic       poll_start = 1'b0;
    logic       cmd_valid = 1'b0;
    typb_byte_s cmd = '0;
    logic       cmd_ready, tx_mod, busy, atqb_ok, atqb_fail, attrib_done;
    logic       rx_sc_on, rx_char_valid, rx_eos;
    logic [7:0] rx_char;
    logic       answer = 1'b0;
    logic [7:0] hdr = 8'h50;
    logic [9:0] runon = 10'h000;
    logic [7:0] exp_bytes[$];
    int         fails = 0;
    int         checks = 0;
    int         done_n = 0;

    always #4 clock = ~clock;
    initial
    begin
        #3;
        forever #40 link_clk = ~link_clk;
    end
    always @(posedge clock) if (attrib_done === 1'b1) done_n++;

    typb_reader_framing dut (.clock(clock), .rst(rst), .link_clk(link_clk), .poll_start(poll_start),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .tx_mod(tx_mod), .rx_sc_on(rx_sc_on),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_eos(rx_eos), .busy(busy),
        .atqb_ok(atqb_ok), .atqb_fail(atqb_fail), .attrib_done(attrib_done));
    typb_card_model card (.link_clk(link_clk), .answer(answer), .hdr(hdr), .runon(runon),
        .rx_sc_on(rx_sc_on), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_eos(rx_eos));

    task automatic print_verdict();
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic bad(input string m);
        fails++;
        $display("BAD %0t %s", $time, m);
    endtask

    task automatic tick();
        @(posedge link_clk);
        #1;
    endtask

    // Applies reset long enough for the link side and checks the idle outputs.
    task automatic do_reset();
        @(posedge clock);
        #1;
        rst = 1'b1;
        repeat (50) @(posedge clock);
        #1;
        checks++; if (tx_mod !== 1'b0 || busy !== 1'b0 || cmd_ready !== 1'b0) bad("outputs during reset");
        rst = 1'b0;
        @(posedge clock);
        #1;
        checks++; if (busy !== 1'b0 || cmd_ready !== 1'b0 || atqb_ok !== 1'b0 || atqb_fail !== 1'b0) bad("after reset");
        checks++; if (attrib_done !== 1'b0 || tx_mod !== 1'b0) bad("pulse after reset");
        repeat (4) @(posedge link_clk);
        #1;
    endtask

    task automatic run_len(input logic lvl, output int len);
        len = 0;
        while (tx_mod === lvl && len < 5000)
        begin
            len++;
            tick();
        end
    endtask

    // Decodes one reader frame on tx_mod and compares it cycle by cycle, except the first and last 8 cycles of each bit.
    task automatic check_frame();
        int t, len, b, off;
        logic e;
        t = 0;
        while (tx_mod !== 1'b1 && t < 40000)
        begin
            tick();
            t++;
        end
        if (t >= 40000)
        begin
            bad("no frame");
            print_verdict();
        end
        run_len(1'b1, len);
        checks++; if (len != 1280) bad("start low length");
        run_len(1'b0, len);
        checks++; if (len != 256) bad("start high length");
        foreach (exp_bytes[k])
            for (int c = 0; c < 1280; c++)
            begin
                b = c / 128;
                off = c % 128;
                e = (b == 0) ? 1'b1 : (b == 9) ? 1'b0 : ~exp_bytes[k][b-1];
                if (off >= 8 && off < 120)
                begin
                    checks++; if (tx_mod !== e) bad("character bit");
                end
                tick();
            end
        run_len(1'b1, len);
        checks++; if (len != 1280) bad("end low missing or late");
    endtask

    task automatic feed_cmd();
        int t;
        foreach (exp_bytes[i])
        begin
            @(posedge clock);
            #1;
            cmd_valid = 1'b1;
            cmd = '{data: exp_bytes[i], last: (i == exp_bytes.size() - 1)};
            t = 0;
            while (cmd_ready !== 1'b1 && t < 40000)
            begin
                @(posedge clock);
                #1;
                t++;
            end
            @(posedge clock);
            #1;
            cmd_valid = 1'b0;
            if (t >= 40000)
            begin
                bad("byte never taken");
                print_verdict();
            end
        end
    endtask

    // One wake-up exchange: checks the wake-up frame, answers, then checks the outcome.
    task automatic poll(input logic [9:0] ro, input logic [7:0] h, input logic ok, input logic [7:0] att[$]);
        int t, d0;
        runon = ro;
        hdr = h;
        exp_bytes = '{WUPB_FRAME[39:32], WUPB_FRAME[31:24], WUPB_FRAME[23:16], WUPB_FRAME[15:8], WUPB_FRAME[7:0]};
        fork
            begin
                @(posedge clock);
                #1;
                poll_start = 1'b1;
                @(posedge clock);
                #1;
                poll_start = 1'b0;
                checks++; if (busy !== 1'b1) bad("busy not raised");
            end
            check_frame();
        join
        checks++; if (cmd_ready !== 1'b0 || busy !== 1'b1) bad("answer judged early");
        tick();
        answer = 1'b1;
        tick();
        answer = 1'b0;
        t = 0;
        while (atqb_ok !== 1'b1 && atqb_fail !== 1'b1 && t < 20000)
        begin
            @(posedge clock);
            #1;
            t++;
        end
        if (t >= 20000)
        begin
            bad("no answer verdict");
            print_verdict();
        end
        checks++; if (atqb_ok !== ok || atqb_fail !== !ok) bad("answer verdict");
        d0 = done_n;
        if (ok)
        begin
            exp_bytes = att;
            fork
                feed_cmd();
                check_frame();
            join
            tick();
            answer = 1'b1;
            tick();
            answer = 1'b0;
        end
        repeat (400) tick();
        checks++; if (done_n != d0 + int'(ok) || busy !== 1'b0) bad("command end");
    endtask

    initial
    begin
        // Held long enough for the link side to see it too.
        do_reset();
        poll(10'h110, 8'h50, 1'b1, '{8'h1D, 8'hA5, 8'h80});
        poll(10'h000, 8'h50, 1'b1, '{8'h3C});
        do_reset();
        poll(10'h014, 8'h51, 1'b0, '{8'h00});
        print_verdict();
    end
endmodule // tb_typeb_reader_char_framing
